// ---- src/acr_regs.sv ----
// result and calibration register bank of the converter
`timescale 1ns/1ps
module acr_regs #(
	parameter int GUARD_CYC = acr_pkg::GUARD_CYC,
	parameter int OFS_SHIFT = acr_pkg::OFS_SHIFT
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// raw conversion stream from the filter
	input  wire logic        raw_valid,
	input  wire logic [23:0] raw_data,
	// calibration outcome
	input  wire logic        cal_done,
	input  wire logic [23:0] cal_offset,
	input  wire logic [23:0] cal_fullscale,
	// command register bits
	input  wire logic        data_format_sel,
	input  wire logic        unipolar_sel,
	// register access from the serial engine
	input  wire logic [1:0]  reg_sel,
	input  wire logic        reg_wr,
	input  wire logic [23:0] reg_wdata,
	output logic      [23:0] reg_rdata,
	// result read framing from the serial engine
	input  wire logic        rd_begin,
	input  wire logic        rd_end,
	// ready output
	output logic             result_ready_n
);

	localparam int GUARD_LEN = GUARD_CYC;
	localparam logic [7:0] GUARD_LAST = 8'(GUARD_CYC - 1);

	acr_sample_if sif ();

	// ==========================================================
	// state
	acr_pkg::acr_state_t st_reg, st_next;
	logic [7:0]  cnt_reg, cnt_next;
	logic [23:0] result_reg, result_next;
	logic [23:0] pend_reg, pend_next;
	logic        pend_vld_reg, pend_vld_next;
	logic        rdy_n_reg, rdy_n_next;
	logic        busy_reg, busy_next;
	logic [23:0] offset_reg, offset_next;
	logic [23:0] fscale_reg, fscale_next;
	logic [23:0] rdata_reg, rdata_next;
	logic        load_now;
	logic        reading;

	// ==========================================================
	// sample path
	assign sif.raw_valid = raw_valid;
	assign sif.raw_data  = raw_data;
	assign sif.offset    = offset_reg;
	assign sif.fullscale = fscale_reg;
	assign sif.fmt_df    = data_format_sel;
	assign sif.fmt_uni   = unipolar_sel;

	acr_corrector #(
		.OFS_SHIFT (OFS_SHIFT)
	) u_corr (
		.sys_clk (sys_clk),
		.rst     (rst),
		.sif     (sif.corr)
	);

	acr_formatter u_fmt (
		.sif (sif.fmt)
	);

	// ==========================================================
	// read tracking
	always_comb begin
		busy_next = busy_reg;
		if (rd_begin)
			busy_next = 1'b1;
		if (rd_end)
			busy_next = 1'b0;
	end

	// a read starting this cycle already blocks the forced high
	assign reading = busy_reg | rd_begin;

	// ==========================================================
	// update sequencer
	always_comb begin
		st_next       = st_reg;
		cnt_next      = cnt_reg;
		result_next   = result_reg;
		pend_next     = pend_reg;
		pend_vld_next = pend_vld_reg;
		rdy_n_next    = rdy_n_reg;
		load_now      = 1'b0;
		// a consumed result takes ready high until the next one
		if (rd_end)
			rdy_n_next = 1'b1;
		unique case (st_reg)
			acr_pkg::ACR_IDLE: begin
				if (pend_vld_reg && !reading) begin
					rdy_n_next = 1'b1;
					cnt_next   = GUARD_LAST;
					st_next    = acr_pkg::ACR_GUARD;
				end
			end
			acr_pkg::ACR_GUARD: begin
				if (cnt_reg == 8'h00) begin
					load_now      = 1'b1;
					result_next   = pend_reg;
					rdy_n_next    = 1'b0;
					pend_vld_next = 1'b0;
					st_next       = acr_pkg::ACR_IDLE;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
		endcase
		// a newer result replaces an unpublished one; set wins
		if (sif.corr_valid) begin
			pend_next     = sif.fmt_data;
			pend_vld_next = 1'b1;
		end
	end

	// ==========================================================
	// calibration registers and read data
	always_comb begin
		offset_next = offset_reg;
		fscale_next = fscale_reg;
		if (reg_wr && reg_sel == acr_pkg::SEL_OFFSET)
			offset_next = reg_wdata;
		if (reg_wr && reg_sel == acr_pkg::SEL_FSCALE)
			fscale_next = reg_wdata;
		// calibration outcome wins over a host write in the same cycle
		if (cal_done) begin
			offset_next = cal_offset;
			fscale_next = cal_fullscale;
		end
		unique case (reg_sel)
			acr_pkg::SEL_RESULT: rdata_next = result_reg;
			acr_pkg::SEL_OFFSET: rdata_next = offset_reg;
			acr_pkg::SEL_FSCALE: rdata_next = fscale_reg;
			acr_pkg::SEL_STATUS: begin
				rdata_next = acr_pkg::RESULT_RST;
				rdata_next[acr_pkg::STATUS_RDY] = rdy_n_reg;
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg       <= acr_pkg::ACR_IDLE;
			cnt_reg      <= 8'h00;
			result_reg   <= acr_pkg::RESULT_RST;
			pend_reg     <= acr_pkg::RESULT_RST;
			pend_vld_reg <= 1'b0;
			rdy_n_reg    <= 1'b1;
			busy_reg     <= 1'b0;
			offset_reg   <= acr_pkg::OFFSET_RST;
			fscale_reg   <= acr_pkg::FSCALE_RST;
			rdata_reg    <= acr_pkg::RESULT_RST;
		end else begin
			st_reg       <= st_next;
			cnt_reg      <= cnt_next;
			result_reg   <= result_next;
			pend_reg     <= pend_next;
			pend_vld_reg <= pend_vld_next;
			rdy_n_reg    <= rdy_n_next;
			busy_reg     <= busy_next;
			offset_reg   <= offset_next;
			fscale_reg   <= fscale_next;
			rdata_reg    <= rdata_next;
		end
	end

	assign result_ready_n = rdy_n_reg;
	assign reg_rdata      = rdata_reg;

	// ==========================================================
	// checks
	a_load_after_high: assert property (@(posedge sys_clk) disable iff (rst)
		load_now |-> rdy_n_reg)
		else $error("result updated while ready was low");

	a_load_drops_ready: assert property (@(posedge sys_clk)
		disable iff (rst)
		load_now |=> !result_ready_n)
		else $error("ready did not fall with the update");

	a_result_is_pend: assert property (@(posedge sys_clk) disable iff (rst)
		load_now |=> result_reg == $past(pend_reg))
		else $error("result register missed pending value");

	a_guard_length: assert property (@(posedge sys_clk) disable iff (rst)
		(st_reg == acr_pkg::ACR_IDLE && st_next == acr_pkg::ACR_GUARD)
		|-> ##GUARD_LEN load_now)
		else $error("guard interval wrong length");

	a_no_force_reading: assert property (@(posedge sys_clk)
		disable iff (rst)
		(busy_reg && !rd_end && !rdy_n_reg) |=> !rdy_n_reg)
		else $error("ready forced high during a read");

	a_busy_span: assert property (@(posedge sys_clk) disable iff (rst)
		(rd_begin && !rd_end) |=> busy_reg)
		else $error("read not tracked as busy");

	a_unipolar_clamp: assert property (@(posedge sys_clk) disable iff (rst)
		(sif.corr_valid && unipolar_sel && !data_format_sel
		&& sif.corr_data[23]) |=> pend_reg == acr_pkg::RESULT_RST)
		else $error("negative result kept in unipolar mode");

	a_offset_binary: assert property (@(posedge sys_clk) disable iff (rst)
		(sif.corr_valid && data_format_sel && !unipolar_sel)
		|=> pend_reg == {~$past(sif.corr_data[23]),
		$past(sif.corr_data[22:0])})
		else $error("offset binary coding wrong");

	a_unity_pass: assert property (@(posedge sys_clk) disable iff (rst)
		(raw_valid && offset_reg == acr_pkg::OFFSET_RST
		&& fscale_reg == acr_pkg::FSCALE_RST)
		|=> sif.corr_data == $past(raw_data))
		else $error("neutral calibration altered the result");

	a_offset_signed: assert property (@(posedge sys_clk) disable iff (rst)
		(raw_valid && raw_data == acr_pkg::RESULT_RST && OFS_SHIFT == 0
		&& fscale_reg == acr_pkg::FSCALE_RST && offset_reg[23]
		&& offset_reg != acr_pkg::NEG_MIN)
		|=> !sif.corr_data[23])
		else $error("negative offset not treated as signed");

	a_host_writes: assert property (@(posedge sys_clk) disable iff (rst)
		(reg_wr && !cal_done && reg_sel == acr_pkg::SEL_OFFSET)
		|=> offset_reg == $past(reg_wdata) ##1
		fscale_reg == $past(fscale_reg, 2))
		else $error("offset write lost or disturbed full-scale");

	a_fscale_write: assert property (@(posedge sys_clk) disable iff (rst)
		(reg_wr && !cal_done && reg_sel == acr_pkg::SEL_FSCALE)
		|=> fscale_reg == $past(reg_wdata))
		else $error("full-scale write lost");

	a_cal_loads: assert property (@(posedge sys_clk) disable iff (rst)
		cal_done |=> offset_reg == $past(cal_offset)
		&& fscale_reg == $past(cal_fullscale))
		else $error("calibration outcome not loaded");

	a_status_mirror: assert property (@(posedge sys_clk) disable iff (rst)
		reg_sel == acr_pkg::SEL_STATUS
		|=> reg_rdata[0] == $past(result_ready_n))
		else $error("status bit does not mirror ready");

	a_correction_used: assert property (@(posedge sys_clk)
		disable iff (rst)
		(raw_valid && fscale_reg == acr_pkg::FSCALE_RST
		&& offset_reg == 24'h000001 && raw_data == 24'h000001)
		|=> sif.corr_data == acr_pkg::RESULT_RST)
		else $error("offset not applied to raw result");

endmodule

// ---- src/acr_pkg.sv ----
// constants and types for the result and calibration register bank
package acr_pkg;

	// ==========================================================
	// widths and register selects
	localparam int        DATA_W     = 24;
	localparam logic [1:0] SEL_RESULT = 2'h0;
	localparam logic [1:0] SEL_OFFSET = 2'h1;
	localparam logic [1:0] SEL_FSCALE = 2'h2;
	localparam logic [1:0] SEL_STATUS = 2'h3;
	localparam int        STATUS_RDY = 0;

	// ==========================================================
	// reset values and correction scaling
	localparam logic [23:0] RESULT_RST = 24'h000000;
	localparam logic [23:0] OFFSET_RST = 24'h000000;
	localparam logic [23:0] FSCALE_RST = 24'h400000;
	localparam logic [25:0] FS_BIAS    = 26'h0400000;
	localparam int          FS_FRAC    = 23;
	localparam int          OFS_SHIFT  = 0;
	localparam logic [23:0] POS_MAX    = 24'h7FFFFF;
	localparam logic [23:0] NEG_MIN    = 24'h800000;

	// ==========================================================
	// guard interval ahead of a result update, in master clocks
	localparam int GUARD_CYC = 24;

	typedef enum logic [1:0] {
		ACR_IDLE,
		ACR_GUARD
	} acr_state_t;

endpackage

// ---- src/acr_sample_if.sv ----
// raw, corrected and formatted sample path between bank modules
`timescale 1ns/1ps
interface acr_sample_if;
	logic        raw_valid;
	logic [23:0] raw_data;
	logic [23:0] offset;
	logic [23:0] fullscale;
	logic        corr_valid;
	logic [23:0] corr_data;
	logic        fmt_df;
	logic        fmt_uni;
	logic [23:0] fmt_data;

	modport top (output raw_valid, raw_data, offset, fullscale, fmt_df,
		fmt_uni, input corr_valid, corr_data, fmt_data);
	modport corr (input raw_valid, raw_data, offset, fullscale,
		output corr_valid, corr_data);
	modport fmt (input corr_data, fmt_df, fmt_uni, output fmt_data);
endinterface

// ---- src/acr_corrector.sv ----
// offset and gain correction of raw results, one register stage
`timescale 1ns/1ps
module acr_corrector #(
	parameter int OFS_SHIFT = acr_pkg::OFS_SHIFT
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// sample path
	acr_sample_if.corr sif
);

	logic               valid_reg, valid_next;
	logic        [23:0] data_reg, data_next;
	logic signed [25:0] ofs_term;
	logic signed [25:0] diff;
	logic signed [25:0] gain;
	logic signed [51:0] prod;
	logic signed [28:0] scaled;

	// ==========================================================
	// linear correction terms
	always_comb begin
		// offset register is signed, scaled, then removed
		ofs_term = 26'($signed(sif.offset)) >>> OFS_SHIFT;
		diff = 26'($signed(sif.raw_data)) - ofs_term;
		// gain grows linearly from a bias, register read as unsigned
		gain = $signed({2'h0, sif.fullscale} + acr_pkg::FS_BIAS);
		prod = 52'(diff) * 52'(gain);
		scaled = 29'(prod >>> acr_pkg::FS_FRAC);
		if (scaled > 29'($signed(acr_pkg::POS_MAX)))
			data_next = acr_pkg::POS_MAX;
		else if (scaled < 29'($signed(acr_pkg::NEG_MIN)))
			data_next = acr_pkg::NEG_MIN;
		else
			data_next = scaled[23:0];
		valid_next = sif.raw_valid;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			valid_reg <= 1'b0;
			data_reg  <= acr_pkg::RESULT_RST;
		end else begin
			valid_reg <= valid_next;
			data_reg  <= data_next;
		end
	end

	assign sif.corr_valid = valid_reg;
	assign sif.corr_data  = data_reg;

endmodule

// ---- src/acr_formatter.sv ----
// unipolar limit and output coding of corrected results
`timescale 1ns/1ps
module acr_formatter (
	// sample path
	acr_sample_if.fmt sif
);

	logic [23:0] lim;

	always_comb begin
		// negative values are floored at zero in unipolar mode
		if (sif.fmt_uni && sif.corr_data[23])
			lim = acr_pkg::RESULT_RST;
		else
			lim = sif.corr_data;
		// offset binary is two's complement with the sign flipped
		if (sif.fmt_df)
			sif.fmt_data = {~lim[23], lim[22:0]};
		else
			sif.fmt_data = lim;
	end

endmodule

// ---- verification/acr_host_model.sv ----
// host controller model: register access and result read framing
`timescale 1ns/1ps
module acr_host_model (
	// clock
	input  wire logic        sys_clk,
	// register port
	input  wire logic [23:0] reg_rdata,
	output logic      [1:0]  reg_sel,
	output logic             reg_wr,
	output logic      [23:0] reg_wdata,
	// read framing
	output logic             rd_begin,
	output logic             rd_end
);
	// ==========================================================
	// bus cycles
	initial begin
		reg_sel = 2'h3;
		reg_wr = 1'b0;
		reg_wdata = 24'h000000;
		rd_begin = 1'b0;
		rd_end = 1'b0;
	end

	task automatic wr(input logic [1:0] s, input logic [23:0] d);
		@(posedge sys_clk);
		reg_sel <= s;
		reg_wr <= 1'b1;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// released data must not keep showing the written word
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [1:0] s, output logic [23:0] d);
		@(posedge sys_clk);
		reg_sel <= s;
		repeat (2) @(posedge sys_clk);
		#1 d = reg_rdata;
	endtask

	// ==========================================================
	// read framing: begin pulse at first clock, end pulse after last bit
	task automatic frame(input logic b);
		@(posedge sys_clk);
		rd_begin <= b;
		rd_end <= !b;
		@(posedge sys_clk);
		rd_begin <= 1'b0;
		rd_end <= 1'b0;
	endtask

	task automatic rd_result(output logic [23:0] d);
		frame(1'b1);
		rd(acr_pkg::SEL_RESULT, d);
		frame(1'b0);
	endtask
endmodule

// ---- verification/acr_regs_test.sv ----
// self-checking bench of the result and calibration register bank
`timescale 1ns/1ps
module acr_regs_test;
	localparam int G = 3;
	logic        sys_clk, rst, raw_valid, cal_done, reg_wr;
	logic        data_format_sel, unipolar_sel, rd_begin, rd_end;
	logic        result_ready_n;
	logic [1:0]  reg_sel;
	logic [23:0] raw_data, cal_offset, cal_fullscale, reg_wdata;
	logic [23:0] reg_rdata, got, r, o, f;
	logic [24:0] s;
	logic [31:0] seed;
	int          n_errors, checks_done;

	// ==========================================================
	// design and host
	acr_regs #(.GUARD_CYC(G)) uut (.sys_clk(sys_clk), .rst(rst),
		.raw_valid(raw_valid), .raw_data(raw_data), .cal_done(cal_done),
		.cal_offset(cal_offset), .cal_fullscale(cal_fullscale),
		.data_format_sel(data_format_sel), .unipolar_sel(unipolar_sel),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .rd_begin(rd_begin), .rd_end(rd_end),
		.result_ready_n(result_ready_n));
	acr_host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.rd_begin(rd_begin), .rd_end(rd_end));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// helpers
	function automatic logic [23:0] rnd();
		repeat (8) seed = {seed[30:0], seed[31]^seed[21]^seed[1]^seed[0]};
		return seed[23:0];
	endfunction

	function automatic logic [23:0] model(input logic [23:0] rr, oo, ff,
		input logic df, uni);
		longint d, p;
		d = longint'(signed'(rr)) - longint'(signed'(oo));
		p = (d * (longint'(ff) + 64'sh400000)) >>> 23;
		if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
		if (p < -64'sh800000) p = -64'sh800000;
		if (uni && p < 0) p = 0;
		return {p[23] ^ df, p[22:0]};
	endfunction

	task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wait_lvl(input logic v, input int n);
		int k;
		k = 0;
		#1;
		while (result_ready_n !== v && k < n) begin
			@(posedge sys_clk);
			#1 k++;
		end
		chk("ready level", {23'h0, result_ready_n}, {23'h0, v});
	endtask

	task automatic pulse(input logic [23:0] rv);
		@(posedge sys_clk);
		raw_valid <= 1'b1;
		raw_data <= rv;
		@(posedge sys_clk);
		raw_valid <= 1'b0;
		raw_data <= ~rv;
	endtask

	task automatic conv(input logic [23:0] rv);
		pulse(rv);
		wait_lvl(1'b1, 4);
		wait_lvl(1'b0, G + 8);
	endtask

	task automatic cal(input logic [23:0] co, cf);
		@(posedge sys_clk);
		cal_done <= 1'b1;
		cal_offset <= co;
		cal_fullscale <= cf;
		@(posedge sys_clk);
		cal_done <= 1'b0;
	endtask

	task automatic one(input logic [23:0] rv, ov, fv, input logic df, u);
		host.wr(acr_pkg::SEL_OFFSET, ov);
		host.wr(acr_pkg::SEL_FSCALE, fv);
		@(posedge sys_clk);
		data_format_sel <= df;
		unipolar_sel <= u;
		conv(rv);
		host.rd(acr_pkg::SEL_STATUS, got);
		chk("status ready", got, 24'h000000);
		host.rd_result(got);
		chk("result", got, model(rv, ov, fv, df, u));
		wait_lvl(1'b1, 3);
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================================
	// watchdog, far beyond the several hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		$display("ERROR watchdog expected done seen timeout");
		stop_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		seed = 32'h000077CC;
		n_errors = 0;
		checks_done = 0;
		rst = 1'b1;
		{raw_valid, cal_done, data_format_sel, unipolar_sel} = 4'h0;
		raw_data = 24'h000000;
		cal_offset = 24'h000000;
		cal_fullscale = 24'h000000;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		host.rd(acr_pkg::SEL_OFFSET, got);
		chk("offset reset", got, acr_pkg::OFFSET_RST);
		host.rd(acr_pkg::SEL_FSCALE, got);
		chk("fullscale reset", got, acr_pkg::FSCALE_RST);
		host.rd(acr_pkg::SEL_STATUS, got);
		chk("status idle", got, 24'h000001);
		host.wr(acr_pkg::SEL_RESULT, 24'h5A5A5A);
		host.rd(acr_pkg::SEL_RESULT, got);
		chk("result read only", got, acr_pkg::RESULT_RST);
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			host.wr(acr_pkg::SEL_OFFSET, r);
			host.rd(acr_pkg::SEL_OFFSET, got);
			chk("offset rw", got, r);
			host.wr(acr_pkg::SEL_FSCALE, ~r);
			host.rd(acr_pkg::SEL_FSCALE, got);
			chk("fullscale rw", got, ~r);
		end
		$display("test reset and access done");
		// saturation, negative offset binary, unipolar clamp corners
		one(24'h7FFFFF, 24'h000000, 24'hFFFFFF, 1'b0, 1'b0);
		one(24'h800000, 24'h000001, 24'h000000, 1'b1, 1'b0);
		one(24'hF00000, 24'h000000, 24'h400000, 1'b0, 1'b1);
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			o = rnd();
			f = rnd();
			one(r, o, f, r[0], o[1]);
		end
		$display("test correction done");
		// calibration loads both; host averages two offsets and writes back
		r = rnd();
		cal(r, 24'h123456);
		host.rd(acr_pkg::SEL_OFFSET, got);
		chk("cal offset", got, r);
		host.rd(acr_pkg::SEL_FSCALE, got);
		chk("cal fullscale", got, 24'h123456);
		o = rnd();
		fork
			host.wr(acr_pkg::SEL_OFFSET, 24'h111111);
			cal(o, 24'h654321);
		join
		host.rd(acr_pkg::SEL_OFFSET, got);
		chk("cal beats write", got, o);
		s = {r[23], r} + {o[23], o};
		host.wr(acr_pkg::SEL_OFFSET, s[24:1]);
		host.rd(acr_pkg::SEL_OFFSET, got);
		chk("averaged offset", got, s[24:1]);
		$display("test calibration done");
		// unread result is overwritten; a read holds back the update
		host.wr(acr_pkg::SEL_OFFSET, 24'h000000);
		host.wr(acr_pkg::SEL_FSCALE, 24'h400000);
		@(posedge sys_clk);
		data_format_sel <= 1'b0;
		unipolar_sel <= 1'b0;
		conv(24'h010000);
		conv(24'h020000);
		host.rd_result(got);
		chk("overwritten", got, 24'h020000);
		conv(24'h030000);
		host.frame(1'b1);
		pulse(24'h040000);
		repeat (G + 10) @(posedge sys_clk);
		#1 chk("ready held", {23'h0, result_ready_n}, 24'h0);
		host.rd(acr_pkg::SEL_RESULT, got);
		chk("result held", got, 24'h030000);
		host.frame(1'b0);
		wait_lvl(1'b1, 3);
		wait_lvl(1'b0, G + 8);
		host.rd_result(got);
		chk("delayed update", got, 24'h040000);
		$display("test overwrite and read hold done");
		stop_test();
	end
endmodule
